// file: design/mio_map.svh
// Purpose: constants of the motion i/o block (counts, bits, timing)
// Assumes: included by bare name wherever the constants are used
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef MIO_MAP_SVH
`define MIO_MAP_SVH

// channel counts
`define MIO_NUM_ENC 8
`define MIO_NUM_PWM 4
`define MIO_NUM_DIN 32
`define MIO_NUM_DOUT 16
`define MIO_NUM_DIRECT 4

// pwm carrier, in hertz
`define MIO_PWM_HZ_MIN 1
`define MIO_PWM_HZ_MAX 32226
`define MIO_PWM_HZ_DEF 32000
`define MIO_PWM_HZ_W 15

// pwm frame: 10-bit resolution, 1024 reference cycles
`define MIO_PWM_RES 10
`define MIO_FRAME_LAST 10'h3ff
`define MIO_INTERLACE_SPLIT 5

// system clock
`define MIO_CLK_HZ 250000000
`define MIO_ACC_W 29

// watchdog configuration word bits
`define MIO_WD_EN_BIT 0
`define MIO_WD_AUTO_BIT 1
`define MIO_WD_TIMEOUT_US 8000
`define MIO_WD_CYCLES (`MIO_WD_TIMEOUT_US * (`MIO_CLK_HZ / 1000000))

// digital inputs shared with the upper encoders and the index masks
`define MIO_SHARED_BASE 0
`define MIO_MASK_BASE_LO 16
`define MIO_MASK_BASE_HI 20

`endif

// file: design/mio_pkg.sv
// Purpose: types of the motion i/o block
// Assumes: constants come from mio_map.svh
// Notes: every module state is one packed struct declared here
package mio_pkg;
`include "mio_map.svh"

  // one pwm channel command as written by the host
  typedef struct packed {
    logic en;                        // channel enable
    logic il;                        // interlaced mode
    logic neg;                       // command sign, drives direction
    logic [`MIO_PWM_RES-1:0] mag;    // duty magnitude in frame cycles
  } mio_pwm_cmd_t;

  // per-encoder controls from the host
  typedef struct packed {
    logic arm_set;                   // pulse: arm index clear
    logic clear;                     // level: hold counter at zero
    logic mask_en;                   // index needs the mask line
    logic mask_pol;                  // mask level that lets index through
  } mio_enc_ctl_t;

  // connector pins after capture
  typedef struct packed {
    logic [`MIO_NUM_DIN-1:0] din;
    logic [`MIO_NUM_DIRECT-1:0] a;
    logic [`MIO_NUM_DIRECT-1:0] b;
    logic [`MIO_NUM_DIRECT-1:0] idx;
    logic estop;
  } mio_pins_t;

  // state of one encoder channel
  typedef struct packed {
    logic pa;
    logic pb;
    logic pidx;
    logic arm;
    logic [31:0] count;
  } mio_enc_st_t;

  // state of the top level
  typedef struct packed {
    mio_pins_t s1;
    mio_pins_t s2;
    logic [`MIO_ACC_W-1:0] acc;
    logic [`MIO_PWM_RES-1:0] ref_cnt;
    mio_pwm_cmd_t [`MIO_NUM_PWM-1:0] shadow;
    mio_pwm_cmd_t [`MIO_NUM_PWM-1:0] act;
    logic [`MIO_NUM_PWM-1:0] pulse;
    logic [`MIO_NUM_PWM-1:0] dir;
    logic [`MIO_NUM_PWM-1:0] ena;
    logic [31:0] wd_cnt;
    logic wd_to;
    logic [`MIO_NUM_DIN-1:0] din_true;
    logic [`MIO_NUM_DIN-1:0] din_inv;
    logic estop_true;
    logic estop_inv;
    logic [`MIO_NUM_DOUT-1:0] dout;
  } mio_top_st_t;

endpackage : mio_pkg

// file: design/mio_enc.sv
// Purpose: one quadrature encoder counter with index and forced clear
// Assumes: a, b, idx and mask are already synchronised to clk
// Notes: index acts on its rising edge only
module mio_enc
  import mio_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // encoder lines
  input wire logic a,
  input wire logic b,
  input wire logic idx,
  input wire logic mask,
  // host side
  input wire mio_enc_ctl_t ctl,
  output logic [31:0] count,
  output logic arm
);

  mio_enc_st_t st;       // registered state
  mio_enc_st_t next_st;  // next state
  logic idx_evt;         // qualified index edge
  logic step;            // one phase moved
  logic up;              // direction of that step

  // decode and counter update
  always_comb begin
    next_st = st;
    next_st.pa = a;
    next_st.pb = b;
    next_st.pidx = idx;
    // with mask_en set, index only counts when the mask line sits at its chosen level
    idx_evt = idx & ~st.pidx & (~ctl.mask_en | (mask == ctl.mask_pol));
    // a change on exactly one phase is a step; both at once is lost
    step = (a ^ st.pa) ^ (b ^ st.pb);
    up = a ^ st.pb;
    if (step) begin
      next_st.count = up ? st.count + 32'h1 : st.count - 32'h1;
    end
    if (st.arm && idx_evt) begin
      next_st.count = '0;
      next_st.arm = 1'b0;
    end
    // a host arm in the same cycle keeps arm set; the armed index still clears the count
    if (ctl.arm_set) begin
      next_st.arm = 1'b1;
    end
    if (ctl.clear) begin
      next_st.count = '0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
  assign arm = st.arm;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_clear_holds_zero: assert property (
    ctl.clear |=> count == 32'h0)
    else $error("counter not zero while clear held");

  a_index_clears_count: assert property (
    (st.arm && idx_evt && !ctl.arm_set) |=> (count == 32'h0) && !arm)
    else $error("armed index did not clear counter and arm");

  a_step_by_one: assert property (
    (!ctl.clear && !(st.arm && idx_evt)) |=>
      ((count - $past(count)) == 32'h1 ||
       ($past(count) - count) == 32'h1 || count == $past(count)))
    else $error("counter moved by more than one");

endmodule : mio_enc

// file: design/mio_top.sv
// Purpose: motion i/o block: encoders, pwm outputs, digital i/o, watchdog
// Assumes: all connector inputs are asynchronous to clk
// Notes: host controls arrive as plain ports on clk
`include "mio_map.svh"

module mio_top
  import mio_pkg::*;
#(
  parameter int WD_CYCLES = `MIO_WD_CYCLES  // watchdog timeout in clocks
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // connector inputs
  input wire logic [`MIO_NUM_DIRECT-1:0] enc_a,
  input wire logic [`MIO_NUM_DIRECT-1:0] enc_b,
  input wire logic [`MIO_NUM_DIRECT-1:0] enc_idx,
  input wire logic [`MIO_NUM_DIN-1:0] din,
  input wire logic estop_in,
  // encoder host side
  input wire mio_enc_ctl_t [`MIO_NUM_ENC-1:0] enc_ctl,
  output logic [`MIO_NUM_ENC-1:0][31:0] enc_count,
  output logic [`MIO_NUM_ENC-1:0] enc_arm,
  // pwm host side
  input wire logic [`MIO_PWM_HZ_W-1:0] pwm_carrier_hz,
  input wire mio_pwm_cmd_t [`MIO_NUM_PWM-1:0] pwm_cmd,
  input wire logic pwm_write,
  // pwm connector outputs
  output logic [`MIO_NUM_PWM-1:0] pwm_pulse,
  output logic [`MIO_NUM_PWM-1:0] pwm_dir,
  output logic [`MIO_NUM_PWM-1:0] pwm_ena,
  // watchdog
  input wire logic [1:0] wd_cfg,
  input wire logic wd_service,
  output logic wd_timeout,
  // digital inputs as seen by the host
  output logic [`MIO_NUM_DIN-1:0] din_true,
  output logic [`MIO_NUM_DIN-1:0] din_inv,
  output logic estop_true,
  output logic estop_inv,
  // digital outputs
  input wire logic [`MIO_NUM_DOUT-1:0] dout_cmd,
  input wire logic [`MIO_NUM_DOUT-1:0] dout_invert,
  output logic [`MIO_NUM_DOUT-1:0] dout
);

  // constants cut to the widths of the signals they meet
  localparam logic [`MIO_ACC_W-1:0] CLK_HZ = `MIO_ACC_W'(`MIO_CLK_HZ);
  localparam logic [`MIO_PWM_HZ_W-1:0] HZ_MIN =
    `MIO_PWM_HZ_W'(`MIO_PWM_HZ_MIN);
  localparam logic [`MIO_PWM_HZ_W-1:0] HZ_MAX =
    `MIO_PWM_HZ_W'(`MIO_PWM_HZ_MAX);
  localparam logic [`MIO_PWM_HZ_W-1:0] HZ_DEF =
    `MIO_PWM_HZ_W'(`MIO_PWM_HZ_DEF);
  localparam logic [31:0] WD_LAST = 32'(WD_CYCLES - 1);
  localparam int SPLIT = `MIO_INTERLACE_SPLIT;

  // state and the combinational helpers of the next-state logic
  mio_top_st_t st;        // registered state
  mio_top_st_t next_st;   // next state
  mio_pins_t pins_in;     // raw connector inputs, gathered
  logic [`MIO_PWM_HZ_W-1:0] hz_eff;          // carrier after range check
  logic [`MIO_ACC_W-1:0] step;               // reference rate per clock
  logic [`MIO_ACC_W-1:0] sum;                // accumulator plus step
  logic tick;                                // one reference cycle
  logic [`MIO_PWM_RES-1:0] ilv;              // interlaced frame position
  logic [`MIO_PWM_RES-1:0] cmp;              // position compared to duty
  logic on;                                  // channel may drive
  logic restart;                             // watchdog restart this cycle
  logic [`MIO_NUM_PWM-1:0] act_en;           // active enables, for checks

  // gather every asynchronous pin into one bundle
  always_comb begin
    pins_in.din = din;
    pins_in.a = enc_a;
    pins_in.b = enc_b;
    pins_in.idx = enc_idx;
    pins_in.estop = estop_in;
  end

  // next state of the whole block
  always_comb begin
    next_st = st;
    // two-flop capture; only the second stage feeds logic
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;

    // out-of-range rates fall back to the default carrier
    if (pwm_carrier_hz >= HZ_MIN && pwm_carrier_hz <= HZ_MAX) begin
      hz_eff = pwm_carrier_hz;
    end else begin
      hz_eff = HZ_DEF;
    end
    // reference rate is carrier times frame length, made by a
    // fractional accumulator so no divider is needed
    step = `MIO_ACC_W'({hz_eff, {`MIO_PWM_RES{1'b0}}});
    sum = st.acc + step;
    tick = (sum >= CLK_HZ);
    next_st.acc = tick ? sum - CLK_HZ : sum;
    if (tick) begin
      next_st.ref_cnt = st.ref_cnt + `MIO_PWM_RES'(1);
    end

    // commands are shadowed and applied at the frame boundary, so
    // a frame never shows half of one duty and half of another
    if (pwm_write) begin
      next_st.shadow = pwm_cmd;
    end
    if (tick && st.ref_cnt == `MIO_FRAME_LAST) begin
      next_st.act = st.shadow;
    end

    // swapping the low and high 5-bit halves of the frame count cuts the frame into short bursts:
    // smoother than contiguous, fewer edges than full alternation
    ilv = {st.ref_cnt[SPLIT-1:0],
           st.ref_cnt[`MIO_PWM_RES-1:SPLIT]};
    // defaults keep the loop helpers from holding a value
    on = 1'b0;
    cmp = '0;
    for (int i = 0; i < `MIO_NUM_PWM; i++) begin
      // a timed-out watchdog silences every channel
      on = st.act[i].en & ~st.wd_to;
      cmp = st.act[i].il ? ilv : st.ref_cnt;
      next_st.pulse[i] = on & (cmp < st.act[i].mag);
      next_st.dir[i] = on & st.act[i].neg;
      next_st.ena[i] = on;
    end

    // watchdog: auto mode uses pwm writes, else the service pulse
    if (wd_cfg[`MIO_WD_AUTO_BIT]) begin
      restart = pwm_write;
    end else begin
      restart = wd_service;
    end
    if (!wd_cfg[`MIO_WD_EN_BIT]) begin
      next_st.wd_cnt = '0;
      next_st.wd_to = 1'b0;
    end else if (restart) begin
      next_st.wd_cnt = '0;
      next_st.wd_to = 1'b0;
    end else if (st.wd_cnt >= WD_LAST) begin
      // counter parks at the limit so the flag never wraps away
      next_st.wd_to = 1'b1;
    end else begin
      next_st.wd_cnt = st.wd_cnt + 32'h1;
    end

    // input mirrors and output drive
    next_st.din_true = st.s2.din;
    next_st.din_inv = ~st.s2.din;
    next_st.estop_true = st.s2.estop;
    next_st.estop_inv = ~st.s2.estop;
    next_st.dout = dout_cmd ^ dout_invert;
  end

  // state register; inverted mirrors start high to match zero inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.din_inv <= '1;
      st.estop_inv <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // encoder channels; the upper four ride on digital inputs 0-11
  for (genvar g = 0; g < `MIO_NUM_ENC; g++) begin : g_enc
    // position among the four channels that ride on digital inputs
    localparam int HI = g - `MIO_NUM_DIRECT;
    localparam int SB = `MIO_SHARED_BASE + 3 * HI;
    if (g < `MIO_NUM_DIRECT) begin : g_direct
      mio_enc u_enc (
        .clk(clk),
        .sys_rst(sys_rst),
        .a(st.s2.a[g]),
        .b(st.s2.b[g]),
        .idx(st.s2.idx[g]),
        .mask(st.s2.din[`MIO_MASK_BASE_LO + g]),
        .ctl(enc_ctl[g]),
        .count(enc_count[g]),
        .arm(enc_arm[g])
      );
    end else begin : g_shared
      // general-purpose use of these inputs leaves junk counts
      mio_enc u_enc (
        .clk(clk),
        .sys_rst(sys_rst),
        .a(st.s2.din[SB]),
        .b(st.s2.din[SB + 1]),
        .idx(st.s2.din[SB + 2]),
        .mask(st.s2.din[`MIO_MASK_BASE_HI + g]),
        .ctl(enc_ctl[g]),
        .count(enc_count[g]),
        .arm(enc_arm[g])
      );
    end
  end

  // outputs straight from the state register
  assign pwm_pulse = st.pulse;
  assign pwm_dir = st.dir;
  assign pwm_ena = st.ena;
  assign wd_timeout = st.wd_to;
  assign din_true = st.din_true;
  assign din_inv = st.din_inv;
  assign estop_true = st.estop_true;
  assign estop_inv = st.estop_inv;
  assign dout = st.dout;

  // active enables flattened for the checks below
  always_comb begin
    for (int i = 0; i < `MIO_NUM_PWM; i++) begin
      act_en[i] = st.act[i].en;
    end
  end

  // all checks run on clk and rest while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_pwm_off_disabled: assert property (
    1'b1 |=> (pwm_pulse & ~$past(act_en)) == '0)
    else $error("disabled pwm channel produced a pulse");

  a_dir_with_enable: assert property (
    (pwm_dir & ~pwm_ena) == '0)
    else $error("direction driven on a disabled channel");

  a_half_duty_edge: assert property (
    (st.act[0].en && !st.act[0].il && !st.wd_to &&
     st.act[0].mag == 10'h200 && st.ref_cnt == 10'h1ff)
      |=> pwm_pulse[0])
    else $error("half duty not high through cycle 511");

  a_half_duty_low: assert property (
    (st.act[0].en && !st.act[0].il && !st.wd_to &&
     st.act[0].mag == 10'h200 && st.ref_cnt == 10'h200)
      |=> !pwm_pulse[0])
    else $error("half duty not low from cycle 512");

  a_wd_disabled: assert property (
    !wd_cfg[0] |=> !wd_timeout && st.wd_cnt == 32'h0)
    else $error("watchdog active while disabled");

  a_wd_auto_restart: assert property (
    (wd_cfg == 2'b11 && pwm_write) |=> st.wd_cnt == 32'h0 && !wd_timeout)
    else $error("pwm write did not restart watchdog");

  a_wd_service_ignored: assert property (
    (wd_cfg == 2'b11 && wd_service && !pwm_write &&
     st.wd_cnt < WD_LAST) |=> st.wd_cnt == $past(st.wd_cnt) + 32'h1)
    else $error("service pulse acted in automatic mode");

  a_wd_expiry: assert property (
    (wd_cfg == 2'b01 && !wd_service && st.wd_cnt >= WD_LAST)
      |=> wd_timeout)
    else $error("watchdog expiry did not raise timeout");

  a_din_mirror: assert property (
    din_inv == ~din_true && estop_inv == ~estop_true)
    else $error("inverted input copy disagrees");

  a_dout_invert: assert property (
    1'b1 |=> dout == ($past(dout_cmd) ^ $past(dout_invert)))
    else $error("digital output not command xor invert");

  a_timeout_silences: assert property (
    st.wd_to |=> pwm_ena == '0 && pwm_pulse == '0 && pwm_dir == '0)
    else $error("pwm outputs not off after watchdog timeout");

  a_interlace_burst: assert property (
    (st.act[1].en && st.act[1].il && !st.wd_to &&
     st.act[1].mag == 10'h200)
      |=> pwm_pulse[1] == !$past(st.ref_cnt[SPLIT-1]))
    else $error("interlaced half duty not in short bursts");

  a_carrier_default: assert property (
    (pwm_carrier_hz == '0 || pwm_carrier_hz > HZ_MAX) |-> hz_eff == HZ_DEF)
    else $error("out-of-range carrier did not use the default");

endmodule : mio_top

// file: sim/mio_quad_field.sv
// Purpose: field side model, one quadrature encoder with index line
// Assumes: the bench asks for at most one step per clock
// Notes: gray order as on a real encoder, four states per line cycle
module mio_quad_field (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic up,
  input wire logic dn,
  input wire logic ix,
  // encoder lines
  output logic a,
  output logic b,
  output logic idx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph; // gray position of the shaft
  initial ph = 2'h0;
  // one gray step per request; up leads a ahead of b
  always @(posedge clk) begin
    if (up) begin
      ph <= ph - 2'h1;
    end else if (dn) begin
      ph <= ph + 2'h1;
    end
  end
  assign a = ph[1];
  assign b = ph[1] ^ ph[0];
  assign idx = ix; // index is a plain level, no stretching
endmodule : mio_quad_field

// file: sim/tb_mio_top.sv
// Purpose: self-checking bench of the motion i/o block
// Assumes: short watchdog through the WD_CYCLES parameter
// Notes: pwm figures are checked with a tolerance, carrier is fractional
module tb_mio_top
  import mio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD = 50; // short watchdog keeps the run brief
  logic clk, sys_rst;
  logic [3:0] enc_a, enc_b, enc_idx;
  logic [31:0] din, din_r, din_true, din_inv;
  logic [8:0] nz; // noise on the unused encoder pins
  logic est, estop_true, estop_inv, pw, svc, wd_timeout;
  logic a0, b0, i0, a4, b4, i4, up0, dn0, ix0, up4, dn4, ix4;
  mio_enc_ctl_t [7:0] ctl;
  logic [7:0][31:0] enc_count;
  logic [7:0] enc_arm;
  logic [14:0] hz;
  mio_pwm_cmd_t [3:0] cmd;
  logic [3:0] pwm_pulse, pwm_dir, pwm_ena;
  logic [1:0] cfg;
  logic [15:0] dcmd, dinv, dout;
  logic [9:0] m3; // random duty of channel 3
  int error_cnt, check_count, cyc_n, seed, t, hi0, hi3, r0, r1, hi2;
  logic p0, p1;
  // encoder 4 rides on the shared digital inputs
  assign enc_a = {nz[2:0], a0};
  assign enc_b = {nz[5:3], b0};
  assign enc_idx = {nz[8:6], i0};
  assign din = {din_r[31:3], i4, b4, a4};
  mio_quad_field u_f0 (.clk(clk), .up(up0), .dn(dn0), .ix(ix0),
    .a(a0), .b(b0), .idx(i0));
  mio_quad_field u_f4 (.clk(clk), .up(up4), .dn(dn4), .ix(ix4),
    .a(a4), .b(b4), .idx(i4));
  mio_top #(.WD_CYCLES(WD)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .din(din),
    .estop_in(est), .enc_ctl(ctl), .enc_count(enc_count),
    .enc_arm(enc_arm), .pwm_carrier_hz(hz), .pwm_cmd(cmd),
    .pwm_write(pw), .pwm_pulse(pwm_pulse), .pwm_dir(pwm_dir),
    .pwm_ena(pwm_ena), .wd_cfg(cfg), .wd_service(svc),
    .wd_timeout(wd_timeout), .din_true(din_true), .din_inv(din_inv),
    .estop_true(estop_true), .estop_inv(estop_inv), .dout_cmd(dcmd),
    .dout_invert(dinv), .dout(dout));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // bench counts within a window
  task automatic rng(input string nm, input int lo, input int hi,
    input int v);
    check_count++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, v);
    end
  endtask : rng
  // expected high clocks of a duty over a window of n clocks
  function automatic int exp_hi(input logic [9:0] mag, input int n);
    return int'(mag) * n / 1024;
  endfunction : exp_hi
  // n steps of encoder 0 or 4, spaced for the input synchronisers
  task automatic step(input logic up, input int n, input logic ch4);
    repeat (n) begin
      @(posedge clk);
      up0 <= up & !ch4;
      dn0 <= !up & !ch4;
      up4 <= up & ch4;
      dn4 <= !up & ch4;
      @(posedge clk);
      {up0, dn0, up4, dn4} <= 4'h0;
      repeat (4) @(posedge clk);
    end
    #1;
  endtask : step
  // index pulse on encoder 0, then time for it to land
  task automatic index0();
    @(posedge clk);
    ix0 <= 1'b1;
    repeat (2) @(posedge clk);
    ix0 <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask : index0
  // rise to rise of pwm channel 0, in clocks, sampled after each edge
  task automatic per(output int n);
    n = 0;
    while (pwm_pulse[0] !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    while (pwm_pulse[0] !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    // just past a rise: count through the high and the low part
    while (pwm_pulse[0] === 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (pwm_pulse[0] !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : per
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 95000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    seed = 83;
    {sys_rst, est, pw, svc, up0, dn0, ix0, up4, dn4, ix4} = 10'h200;
    {din_r, nz, ctl, cmd, cfg, dcmd, dinv} = '0;
    hz = 15'h7de2;
    repeat (6) @(posedge clk);
    #1;
    chk("rst din_inv", 32'hffffffff, din_inv);
    chk("rst estop_inv", 32'h1, 32'(estop_inv));
    chk("rst count", 32'h0, enc_count[0]);
    sys_rst <= 1'b0;
    // digital mirrors and outputs, random
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      din_r <= $random(seed);
      nz <= 9'($random(seed));
      est <= 1'($random(seed));
      dcmd <= 16'($random(seed));
      dinv <= 16'($random(seed));
      repeat (4) @(posedge clk);
      #1;
      chk("din_true", din, din_true);
      chk("din_inv", ~din, din_inv);
      chk("estop_true", 32'(est), 32'(estop_true));
      chk("estop_inv", 32'(!est), 32'(estop_inv));
      chk("dout", 32'(dcmd ^ dinv), 32'(dout));
    end
    // quadrature both ways, shared-pin encoder
    step(1'b1, 5, 1'b0);
    chk("cnt0 up", 32'h5, enc_count[0]);
    step(1'b0, 2, 1'b0);
    chk("cnt0 down", 32'h3, enc_count[0]);
    step(1'b1, 6, 1'b1);
    chk("cnt4", 32'h6, enc_count[4]);
    // forced clear holds through steps
    ctl[0].clear <= 1'b1;
    step(1'b1, 2, 1'b0);
    chk("held", 32'h0, enc_count[0]);
    ctl[0].clear <= 1'b0;
    step(1'b1, 3, 1'b0);
    ctl[0].arm_set <= 1'b1;
    @(posedge clk);
    ctl[0].arm_set <= 1'b0;
    @(posedge clk);
    #1;
    chk("armed", 32'h1, 32'(enc_arm[0]));
    index0();
    chk("idx count", 32'h0, enc_count[0]);
    chk("idx arm", 32'h0, 32'(enc_arm[0]));
    // masked index: blocked, then let through
    ctl[0].mask_en <= 1'b1;
    ctl[0].mask_pol <= 1'b1;
    din_r[16] <= 1'b0;
    step(1'b1, 2, 1'b0);
    ctl[0].arm_set <= 1'b1;
    @(posedge clk);
    ctl[0].arm_set <= 1'b0;
    index0();
    chk("mask count", 32'h2, enc_count[0]);
    chk("mask arm", 32'h1, 32'(enc_arm[0]));
    din_r[16] <= 1'b1;
    index0();
    chk("pass count", 32'h0, enc_count[0]);
    // pwm: normal, interlaced, disabled, random duty
    m3 = 10'($random(seed));
    cmd[0] <= '{1'b1, 1'b0, 1'b1, 10'h200};
    cmd[1] <= '{1'b1, 1'b1, 1'b0, 10'h200};
    cmd[2] <= '{1'b0, 1'b0, 1'b1, 10'h200};
    cmd[3] <= '{1'b1, 1'b0, 1'b0, m3};
    pw <= 1'b1;
    @(posedge clk);
    pw <= 1'b0;
    repeat (8000) @(posedge clk);
    {hi0, hi3, r0, r1, hi2, p0, p1} = '0;
    for (int i = 0; i < 15516; i++) begin
      @(posedge clk);
      #1;
      hi0 += int'(pwm_pulse[0]);
      hi3 += int'(pwm_pulse[3]);
      hi2 += int'(pwm_pulse[2]);
      r0 += int'(pwm_pulse[0] & !p0);
      r1 += int'(pwm_pulse[1] & !p1);
      {p0, p1} = {pwm_pulse[0], pwm_pulse[1]};
    end
    t = exp_hi(10'h200, 15516);
    rng("duty0", t - 310, t + 310, hi0);
    t = exp_hi(m3, 15516);
    rng("duty3", t - 310, t + 310, hi3);
    rng("edges0", 1, 3, r0);
    rng("edges1", 60, 70, r1);
    chk("off pulse", 32'h0, 32'(hi2));
    chk("ena", 32'hb, 32'(pwm_ena));
    chk("dir", 32'h1, 32'(pwm_dir));
    per(t);
    rng("period max", 7754, 7762, t);
    hz <= 15'h0;
    repeat (8000) @(posedge clk);
    per(t);
    rng("period def", 7809, 7817, t);
    // watchdog: off, serviced, expiring, auto restart
    repeat (120) @(posedge clk);
    #1;
    chk("wd off", 32'h0, 32'(wd_timeout));
    cfg <= 2'h1;
    repeat (5) begin
      @(posedge clk);
      svc <= 1'b1;
      @(posedge clk);
      svc <= 1'b0;
      repeat (30) @(posedge clk);
    end
    #1;
    chk("wd served", 32'h0, 32'(wd_timeout));
    repeat (60) @(posedge clk);
    #1;
    chk("wd expired", 32'h1, 32'(wd_timeout));
    svc <= 1'b1;
    @(posedge clk);
    svc <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("wd restart", 32'h0, 32'(wd_timeout));
    // a service pulse well before expiry must not delay the timeout
    cfg <= 2'h3;
    repeat (20) @(posedge clk);
    svc <= 1'b1;
    @(posedge clk);
    svc <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk("wd svc ignored", 32'h1, 32'(wd_timeout));
    pw <= 1'b1;
    @(posedge clk);
    pw <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("wd auto", 32'h0, 32'(wd_timeout));
    stop_test();
  end
endmodule : tb_mio_top
